/* debug_rom_table_core_entries_test.sv */
`timescale 1ns/100ps
module debug_rom_table_core_entries_test;
	import drt_pkg::*;

	// ------------------------------------------------------------------
	// signals and model state
	// ------------------------------------------------------------------
	logic        clk;
	logic        rst;
	logic [4:0]  configured_core_count;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	int          err_total;
	int          cmp_count;
	int unsigned exp_q [$];
	// component locations of the trigger interfaces of cores 4 to 11
	int unsigned loc_tab [8] = '{32'h2f_0000, 32'h37_0000, 32'h3f_0000,
		32'h47_0000, 32'h4f_0000, 32'h57_0000, 32'h5f_0000, 32'h67_0000};

	drt_rom_table DUT (
		.clk                   (clk),
		.rst                   (rst),
		.configured_core_count (configured_core_count),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hsize                 (hsize),
		.hready                (hreadyout),
		.hwdata                (hwdata),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.hrdata                (hrdata)
	);

	drt_debugger_model m (
		.clk    (clk),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata),
		.hready (hreadyout),
		.hrdata (hrdata)
	);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: read %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// the strap is only taken after a reset, so each count needs one
	task automatic restart(input logic [4:0] cores);
		@(posedge clk);
		rst <= 1'b1;
		configured_core_count <= cores;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [31:0] a;
		logic [31:0] e;
		int          cc;
		rst = 1'b1;
		configured_core_count = 5'h00;
		err_total = 0;
		cmp_count = 0;
		void'($urandom(74340));
		for (int c = 0; c <= 14; c++) begin
			cc = (c == 14) ? 31 : c;
			restart(5'(cc));
			for (int i = 0; i < 8; i++) begin
				a = 32'h18 + 32'(4 * i);
				exp_q.push_back((cc >= 5 + i) ? (loc_tab[i] | 32'h3) : 32'h0);
				e = exp_q[0];
				m.xfer(a, 1'b0, 32'h0, int'($urandom_range(2)), rd);
				check(rd & 32'hfff, e & 32'hfff);
				if (i < 4) check(m.locate(0, rd), e & ~32'hfff);
				else check(m.locate(0, rd), e & ~32'hfff);
				m.xfer(a, 1'b1, $urandom, 0, rd);
				m.xfer(a, 1'b0, 32'h0, 0, rd);
				check(rd, exp_q.pop_front());
			end
			// the entry writes above raise the flag; control clears it
			m.xfer(32'(DRT_STATUS_OFFSET), 1'b0, 32'h0, 0, rd);
			e = (32'h1 << DRT_STAT_RO_WRITE_BIT)
				| (32'h1 << DRT_STAT_CAPTURED_BIT) | 32'(cc);
			check(rd, e);
			m.xfer(32'(DRT_CONTROL_OFFSET), 1'b1,
				(32'h1 << DRT_CTRL_CLR_FLAG_BIT)
				| (32'h1 << DRT_CTRL_CLR_COUNT_BIT), 0, rd);
			// counter was cleared behind the control write
			m.xfer(32'(DRT_COUNT_OFFSET), 1'b0, 32'h0, 0, rd);
			check(rd, 32'h0);
			m.xfer(32'(DRT_STATUS_OFFSET), 1'b0, 32'h0, 0, rd);
			check(rd, e & ~(32'h1 << DRT_STAT_RO_WRITE_BIT));
			// an unmapped word reads as zero
			a = {20'h0, 4'h1 + 4'($urandom_range(14)), 8'($urandom) & 8'hfc};
			m.xfer(a, 1'b0, 32'h0, 1, rd);
			check(rd, 32'h0);
		end
		final_report();
	end

	// cut a hang short, well beyond the under two thousand cycles needed
	initial begin
		#(50 * 20000);
		err_total++;
		final_report();
	end
endmodule // debug_rom_table_core_entries_test

/* drt_core_count_capture.sv */
`timescale 1ns/100ps
module drt_core_count_capture
	import drt_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// strap from cluster configuration
	input  wire logic [4:0] configured_core_count,
	// held value
	output logic      [4:0] core_count,
	output logic            captured
);

	// ------------------------------------------------------------------
	// capture once, on the first edge after reset release
	// ------------------------------------------------------------------
	// the strap is taken by a clocked load, never by the reset itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_count <= DRT_CORE_COUNT_RESET;
			captured   <= 1'b0;
		end else if (!captured) begin
			core_count <= configured_core_count;
			captured   <= 1'b1;
		end
	end

endmodule // drt_core_count_capture

/* drt_debugger_model.sv */
`timescale 1ns/100ps
module drt_debugger_model
	import drt_pkg::*;
(
	// clock
	input  wire logic        clk,
	// request towards the table
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	// answer from the table
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = DRT_HSIZE_WORD;
		hwdata = 32'h0;
	end

	// where a listed component sits, from the entry's offset field
	function automatic logic [31:0] locate(input logic [31:0] base,
		input logic [31:0] entry);
		return base + {entry[31:12], 12'h000};
	endfunction

	// one single word transfer; gap idles first to act as a slow reader
	task automatic xfer(input logic [31:0] addr, input logic wr,
		input logic [31:0] wd, input int gap, output logic [31:0] rd);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= DRT_HSIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		// released address lines show a changed pattern, not the old one
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~addr;
		hwdata <= wr ? wd : ~wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		hwdata <= ~wd;
	endtask
endmodule // drt_debugger_model

/* drt_entry_encoder.sv */
`timescale 1ns/100ps
module drt_entry_encoder
	import drt_pkg::*;
(
	// slot being encoded
	input  wire logic [3:0]  slot,
	// held core count
	input  wire logic [4:0]  core_count,
	// entry word
	output logic      [31:0] entry
);

	// ------------------------------------------------------------------
	// per-slot lookups
	// ------------------------------------------------------------------
	function automatic logic [19:0] slot_offset(input logic [3:0] s);
		case (s)
			4'h6:    slot_offset = DRT_CORE4_XTI_OFFSET;
			4'h7:    slot_offset = DRT_CORE5_XTI_OFFSET;
			4'h8:    slot_offset = DRT_CORE6_XTI_OFFSET;
			4'h9:    slot_offset = DRT_CORE7_XTI_OFFSET;
			4'ha:    slot_offset = DRT_CORE8_XTI_OFFSET;
			4'hb:    slot_offset = DRT_CORE9_XTI_OFFSET;
			4'hc:    slot_offset = DRT_CORE10_XTI_OFFSET;
			4'hd:    slot_offset = DRT_CORE11_XTI_OFFSET;
			default: slot_offset = 20'h00000;
		endcase
	endfunction

	// unknown slots get a threshold no count reaches
	function automatic logic [5:0] slot_threshold(input logic [3:0] s);
		case (s)
			4'h6:    slot_threshold = {1'b0, DRT_SLOT_SIX_MIN_CORES};
			4'h7:    slot_threshold = {1'b0, DRT_SLOT_SEVEN_MIN_CORES};
			4'h8:    slot_threshold = {1'b0, DRT_SLOT_EIGHT_MIN_CORES};
			4'h9:    slot_threshold = {1'b0, DRT_SLOT_NINE_MIN_CORES};
			4'ha:    slot_threshold = {1'b0, DRT_SLOT_TEN_MIN_CORES};
			4'hb:    slot_threshold = {1'b0, DRT_SLOT_ELEVEN_MIN_CORES};
			4'hc:    slot_threshold = {1'b0, DRT_SLOT_TWELVE_MIN_CORES};
			4'hd:    slot_threshold = {1'b0, DRT_SLOT_THIRTEEN_MIN_CORES};
			default: slot_threshold = 6'h3f;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// entry assembly
	// ------------------------------------------------------------------
	logic        populated;
	logic [31:0] entry_word;

	assign populated  = {1'b0, core_count} >= slot_threshold(slot);
	assign entry_word = ({12'h000, slot_offset(slot)} << DRT_OFFSET_LSB)
		| (32'(DRT_PIDV_VALUE) << DRT_PIDV_BIT)
		| (32'(DRT_PRESENT_VALUE) << DRT_PRESENT_LSB);
	// bits 11:3 are never set by the terms above
	assign entry = populated ? entry_word : 32'h00000000;

endmodule // drt_entry_encoder

/* drt_pkg.sv */
package drt_pkg;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] DRT_SLOT_SIX_OFFSET      = 12'h018;
	localparam logic [11:0] DRT_SLOT_SEVEN_OFFSET    = 12'h01c;
	localparam logic [11:0] DRT_SLOT_EIGHT_OFFSET    = 12'h020;
	localparam logic [11:0] DRT_SLOT_NINE_OFFSET     = 12'h024;
	localparam logic [11:0] DRT_SLOT_TEN_OFFSET      = 12'h028;
	localparam logic [11:0] DRT_SLOT_ELEVEN_OFFSET   = 12'h02c;
	localparam logic [11:0] DRT_SLOT_TWELVE_OFFSET   = 12'h030;
	localparam logic [11:0] DRT_SLOT_THIRTEEN_OFFSET = 12'h034;
	localparam logic [11:0] DRT_STATUS_OFFSET        = 12'h040;
	localparam logic [11:0] DRT_CONTROL_OFFSET       = 12'h044;
	localparam logic [11:0] DRT_COUNT_OFFSET         = 12'h048;

	// ------------------------------------------------------------------
	// slot numbering
	// ------------------------------------------------------------------
	localparam logic [3:0] DRT_FIRST_SLOT = 4'h6;
	localparam int         DRT_SLOT_COUNT = 8;

	// ------------------------------------------------------------------
	// component offsets, in units of 4 kbyte
	// ------------------------------------------------------------------
	localparam logic [19:0] DRT_CORE4_XTI_OFFSET  = 20'h002f0;
	localparam logic [19:0] DRT_CORE5_XTI_OFFSET  = 20'h00370;
	localparam logic [19:0] DRT_CORE6_XTI_OFFSET  = 20'h003f0;
	localparam logic [19:0] DRT_CORE7_XTI_OFFSET  = 20'h00470;
	localparam logic [19:0] DRT_CORE8_XTI_OFFSET  = 20'h004f0;
	localparam logic [19:0] DRT_CORE9_XTI_OFFSET  = 20'h00570;
	localparam logic [19:0] DRT_CORE10_XTI_OFFSET = 20'h005f0;
	localparam logic [19:0] DRT_CORE11_XTI_OFFSET = 20'h00670;

	// ------------------------------------------------------------------
	// least core count that populates each slot
	// ------------------------------------------------------------------
	localparam logic [4:0] DRT_SLOT_SIX_MIN_CORES      = 5'h05;
	localparam logic [4:0] DRT_SLOT_SEVEN_MIN_CORES    = 5'h06;
	localparam logic [4:0] DRT_SLOT_EIGHT_MIN_CORES    = 5'h07;
	localparam logic [4:0] DRT_SLOT_NINE_MIN_CORES     = 5'h08;
	localparam logic [4:0] DRT_SLOT_TEN_MIN_CORES      = 5'h09;
	localparam logic [4:0] DRT_SLOT_ELEVEN_MIN_CORES   = 5'h0a;
	localparam logic [4:0] DRT_SLOT_TWELVE_MIN_CORES   = 5'h0b;
	localparam logic [4:0] DRT_SLOT_THIRTEEN_MIN_CORES = 5'h0c;

	// ------------------------------------------------------------------
	// entry layout
	// ------------------------------------------------------------------
	localparam int         DRT_OFFSET_LSB    = 12;
	localparam int         DRT_PIDV_BIT      = 2;
	localparam int         DRT_PRESENT_LSB   = 0;
	localparam logic       DRT_PIDV_VALUE    = 1'b0;
	localparam logic [1:0] DRT_PRESENT_VALUE = 2'h3;

	// ------------------------------------------------------------------
	// status, control and counter layout
	// ------------------------------------------------------------------
	localparam int         DRT_STAT_COUNT_LSB     = 0;
	localparam int         DRT_STAT_CAPTURED_BIT  = 8;
	localparam int         DRT_STAT_RO_WRITE_BIT  = 16;
	localparam int         DRT_CTRL_CLR_FLAG_BIT  = 0;
	localparam int         DRT_CTRL_CLR_COUNT_BIT = 1;
	localparam int         DRT_COUNT_WIDTH        = 16;
	localparam logic [4:0] DRT_CORE_COUNT_RESET   = 5'h00;

	// ------------------------------------------------------------------
	// ahb-lite encodings
	// ------------------------------------------------------------------
	localparam logic [2:0] DRT_HSIZE_WORD = 3'h2;
	localparam logic       DRT_HRESP_OKAY = 1'b0;

endpackage

/* drt_rom_table.sv */
// What this block does
// - every entry exists; an unpopulated slot reads all zero
// - entries are 32-bit read-only; writes leave them unchanged
// - populated entry reads zero in bits 11 to 3
// - populated entry reads power domain id valid bit as zero
// - populated entry reads present field as binary 11
// - slot six: core 4 trigger interface, five or more cores
// - slot seven: core 5 trigger interface, six or more cores
// - slot eight: core 6 trigger interface, seven or more cores
// - slot nine: core 7 trigger interface, eight or more cores
// - slot ten: core 8 trigger interface, nine or more cores
// - slot eleven: core 9 trigger interface, ten or more cores
// - slot twelve: core 10 trigger interface, eleven or more cores
// - slot thirteen: core 11 trigger interface, twelve or more cores
`timescale 1ns/100ps
module drt_rom_table
	import drt_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// core count strap from cluster configuration
	input  wire logic [4:0]  configured_core_count,
	// ahb-lite address phase
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	// ahb-lite data phase
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// word match on the low 12 bits; hsel covers the rest of the map
	function automatic logic word_at(input logic [11:0] addr,
		input logic [11:0] offset);
		word_at = addr[11:2] == offset[11:2];
	endfunction

	// ------------------------------------------------------------------
	// core count capture
	// ------------------------------------------------------------------
	logic [4:0] core_count;
	logic       count_captured;

	drt_core_count_capture u_capture (
		.clk                   (clk),
		.rst                   (rst),
		.configured_core_count (configured_core_count),
		.core_count            (core_count),
		.captured              (count_captured)
	);

	// ------------------------------------------------------------------
	// entry words
	// ------------------------------------------------------------------
	logic [31:0] entry_word [DRT_SLOT_COUNT];

	for (genvar i = 0; i < DRT_SLOT_COUNT; i++) begin : g_slot
		drt_entry_encoder u_entry (
			.slot       (4'(DRT_FIRST_SLOT + 4'(i))),
			.core_count (core_count),
			.entry      (entry_word[i])
		);
	end

	logic [31:0] table_entry_slot_six;
	logic [31:0] table_entry_slot_seven;
	logic [31:0] table_entry_slot_eight;
	logic [31:0] table_entry_slot_nine;
	logic [31:0] table_entry_slot_ten;
	logic [31:0] table_entry_slot_eleven;
	logic [31:0] table_entry_slot_twelve;
	logic [31:0] table_entry_slot_thirteen;

	assign table_entry_slot_six      = entry_word[0];
	assign table_entry_slot_seven    = entry_word[1];
	assign table_entry_slot_eight    = entry_word[2];
	assign table_entry_slot_nine     = entry_word[3];
	assign table_entry_slot_ten      = entry_word[4];
	assign table_entry_slot_eleven   = entry_word[5];
	assign table_entry_slot_twelve   = entry_word[6];
	assign table_entry_slot_thirteen = entry_word[7];

	// ------------------------------------------------------------------
	// address phase
	// ------------------------------------------------------------------
	logic        addr_taken;
	logic        read_taken;
	logic        write_taken;
	logic [11:0] addr_low;

	// no wait states, so hready is our own hreadyout
	assign addr_taken  = hsel & htrans[1] & hready;
	assign read_taken  = addr_taken & ~hwrite;
	assign write_taken = addr_taken & hwrite & (hsize == DRT_HSIZE_WORD);
	assign addr_low    = haddr[11:0];

	// ------------------------------------------------------------------
	// read decode, on the address phase
	// ------------------------------------------------------------------
	logic rd_six;
	logic rd_seven;
	logic rd_eight;
	logic rd_nine;
	logic rd_ten;
	logic rd_eleven;
	logic rd_twelve;
	logic rd_thirteen;
	logic rd_status;
	logic rd_count;

	// every entry decodes whatever the core count
	assign rd_six      = word_at(addr_low, DRT_SLOT_SIX_OFFSET);
	assign rd_seven    = word_at(addr_low, DRT_SLOT_SEVEN_OFFSET);
	assign rd_eight    = word_at(addr_low, DRT_SLOT_EIGHT_OFFSET);
	assign rd_nine     = word_at(addr_low, DRT_SLOT_NINE_OFFSET);
	assign rd_ten      = word_at(addr_low, DRT_SLOT_TEN_OFFSET);
	assign rd_eleven   = word_at(addr_low, DRT_SLOT_ELEVEN_OFFSET);
	assign rd_twelve   = word_at(addr_low, DRT_SLOT_TWELVE_OFFSET);
	assign rd_thirteen = word_at(addr_low, DRT_SLOT_THIRTEEN_OFFSET);
	assign rd_status   = word_at(addr_low, DRT_STATUS_OFFSET);
	assign rd_count    = word_at(addr_low, DRT_COUNT_OFFSET);

	// ------------------------------------------------------------------
	// data phase state
	// ------------------------------------------------------------------
	logic        dp_write;
	logic [11:0] dp_addr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dp_write <= 1'b0;
			dp_addr  <= 12'h000;
		end else if (hready) begin
			dp_write <= write_taken;
			dp_addr  <= addr_low;
		end
	end

	// ------------------------------------------------------------------
	// write decode, on the data phase
	// ------------------------------------------------------------------
	logic wr_entry;
	logic wr_status;
	logic wr_count;
	logic wr_control;
	logic wr_read_only;

	assign wr_entry   = dp_write
		& (dp_addr[11:2] >= DRT_SLOT_SIX_OFFSET[11:2])
		& (dp_addr[11:2] <= DRT_SLOT_THIRTEEN_OFFSET[11:2]);
	assign wr_status  = dp_write & word_at(dp_addr, DRT_STATUS_OFFSET);
	assign wr_count   = dp_write & word_at(dp_addr, DRT_COUNT_OFFSET);
	assign wr_control = dp_write & word_at(dp_addr, DRT_CONTROL_OFFSET);
	// entries have no storage, so a write can only be noted
	assign wr_read_only = wr_entry | wr_status | wr_count;

	logic clr_flag;
	logic clr_count;

	assign clr_flag  = wr_control & hwdata[DRT_CTRL_CLR_FLAG_BIT];
	assign clr_count = wr_control & hwdata[DRT_CTRL_CLR_COUNT_BIT];

	// ------------------------------------------------------------------
	// read-only write flag
	// ------------------------------------------------------------------
	logic ro_write_seen;
	logic next_ro_write_seen;

	// a write landing with the clear keeps the flag up
	assign next_ro_write_seen = wr_read_only | (ro_write_seen & ~clr_flag);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ro_write_seen <= 1'b0;
		end else begin
			ro_write_seen <= next_ro_write_seen;
		end
	end

	// ------------------------------------------------------------------
	// transfer counter
	// ------------------------------------------------------------------
	// wraps silently; a debugger only wants deltas
	logic [DRT_COUNT_WIDTH-1:0] xfer_count;
	logic [DRT_COUNT_WIDTH-1:0] next_xfer_count;
	logic [DRT_COUNT_WIDTH-1:0] count_base;

	assign count_base      = clr_count ? '0 : xfer_count;
	assign next_xfer_count = count_base
		+ DRT_COUNT_WIDTH'(addr_taken);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xfer_count <= '0;
		end else begin
			xfer_count <= next_xfer_count;
		end
	end

	// ------------------------------------------------------------------
	// status word
	// ------------------------------------------------------------------
	logic [31:0] status_word;
	logic [31:0] count_word;

	assign status_word = (32'(core_count) << DRT_STAT_COUNT_LSB)
		| (32'(count_captured) << DRT_STAT_CAPTURED_BIT)
		| (32'(ro_write_seen) << DRT_STAT_RO_WRITE_BIT);
	assign count_word  = 32'(xfer_count);

	// ------------------------------------------------------------------
	// read data select
	// ------------------------------------------------------------------
	// control reads as zero, unmapped words read as zero
	logic [31:0] next_rdata;

	assign next_rdata = ({32{rd_six}}      & table_entry_slot_six)
		| ({32{rd_seven}}    & table_entry_slot_seven)
		| ({32{rd_eight}}    & table_entry_slot_eight)
		| ({32{rd_nine}}     & table_entry_slot_nine)
		| ({32{rd_ten}}      & table_entry_slot_ten)
		| ({32{rd_eleven}}   & table_entry_slot_eleven)
		| ({32{rd_twelve}}   & table_entry_slot_twelve)
		| ({32{rd_thirteen}} & table_entry_slot_thirteen)
		| ({32{rd_status}}   & status_word)
		| ({32{rd_count}}    & count_word);

	// ------------------------------------------------------------------
	// read data register
	// ------------------------------------------------------------------
	// loaded at the address edge so hrdata stands through the data phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (hready) begin
			hrdata <= read_taken ? next_rdata : 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// response
	// ------------------------------------------------------------------
	// every access completes in one data cycle with okay
	assign hreadyout = 1'b1;
	assign hresp     = DRT_HRESP_OKAY;

endmodule // drt_rom_table

/* drt_rom_table_asserts.sv */
`timescale 1ns/100ps
module drt_rom_table_asserts
	import drt_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// strap and bus
	input wire logic [4:0]  configured_core_count,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata
);
	// strap is captured at the first edge after release
	logic settled;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) settled <= 1'b0;
		else settled <= 1'b1;
	end

	wire        taken    = hsel & htrans[1] & hready;
	wire        at_entry = (haddr[11:0] >= 12'h018) &&
		(haddr[11:0] <= 12'h034) && (haddr[1:0] == 2'h0);
	wire        rd_entry = taken && !hwrite && at_entry && settled;
	wire [11:0] rel      = haddr[11:0] - 12'h018;
	wire [2:0]  idx      = rel[4:2];
	wire [19:0] offs     = 20'h002f0 + {10'h0, idx, 7'h0};
	wire [31:0] exp_word = (configured_core_count >= 5'h05 + {2'h0, idx}) ?
		{offs, 12'h003} : 32'h0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_ready_high: assert property (hreadyout)
		else $error("hreadyout dropped");
	a_resp_okay: assert property (hresp == DRT_HRESP_OKAY)
		else $error("response not okay");
	a_reserved_zero: assert property (
		rd_entry |=> hrdata[11:3] == 9'h0) else $error("bits 11:3 set");
	a_pidv_clear: assert property (
		rd_entry |=> !hrdata[2]) else $error("power id valid set");
	a_present_or_zero: assert property (
		rd_entry |=> (hrdata == 32'h0) != (hrdata[1:0] == 2'h3))
		else $error("present field wrong");
	a_slot_six_value: assert property (
		rd_entry && idx == 3'h0 |=> hrdata == $past(exp_word))
		else $error("slot six value wrong");
	a_mid_slot_value: assert property (
		rd_entry && idx inside {[3'h1:3'h6]} |=> hrdata == $past(exp_word))
		else $error("middle slot value wrong");
	a_last_slot_value: assert property (
		rd_entry && idx == 3'h7 ##1 1'b1 |-> hrdata == $past(exp_word, 1))
		else $error("slot thirteen value wrong");
	a_idle_data_zero: assert property (
		!taken || hwrite |=> hrdata == 32'h0)
		else $error("data not zero after idle or write");
endmodule // drt_rom_table_asserts

bind drt_rom_table drt_rom_table_asserts u_asserts (
	.clk                   (clk),
	.rst                   (rst),
	.configured_core_count (configured_core_count),
	.hsel                  (hsel),
	.haddr                 (haddr),
	.htrans                (htrans),
	.hwrite                (hwrite),
	.hsize                 (hsize),
	.hready                (hready),
	.hwdata                (hwdata),
	.hreadyout             (hreadyout),
	.hresp                 (hresp),
	.hrdata                (hrdata)
);
